// ==== src/sfc_pkg.sv ====
package sfc_pkg;
    // register offsets (byte addresses, one aligned word each)
    localparam logic [3:0] OFF_BAUD_OR_ALTSTAT = 4'h0;
    localparam logic [3:0] OFF_SPARE_OR_ALTCTL = 4'h4;
    localparam logic [3:0] OFF_FRAME_OR_ALTCTL2 = 4'h8;
    localparam logic [3:0] OFF_SECOND_STATUS  = 4'hC;
    // frame_control_one fields
    localparam int FC_LOOP   = 7;
    localparam int FC_WAIT   = 6;
    localparam int FC_SRC    = 5;
    localparam int FC_LEN9   = 4;
    localparam int FC_WAKE   = 3;
    localparam int FC_IDLE   = 2;
    localparam int FC_PEN    = 1;
    localparam int FC_PTYPE  = 0;
    // alt_line_status fields
    localparam int AS_EDGE   = 7;
    localparam int AS_BVAL   = 2;
    localparam int AS_BERR   = 1;
    localparam int AS_BRK    = 0;
    localparam logic [7:0] AS_W1C_MASK = 8'h83;
    // alt control 1 (mask) and alt control 2 fields
    localparam int AC2_BMODE_HI = 2;
    localparam int AC2_BMODE_LO = 1;
    localparam int AC2_BRK_EN   = 0;
    // second status register fields
    localparam int SS_ALT_MAP = 7;
    localparam int SS_RX_POL  = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // bit error sample points, in 1/16 bit ticks
    localparam logic [3:0] TICK_MODE1 = 4'h8;  // 9th tick
    localparam logic [3:0] TICK_MODE2 = 4'hC;  // 13th tick
    localparam logic [1:0] BMODE_OFF = 2'h0;
    localparam logic [1:0] BMODE_9   = 2'h1;
    localparam logic [1:0] BMODE_13  = 2'h2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       rx_pin;     // transmit pin level, read in single-wire mode
        logic       tx_bit;     // bit currently sent by transmitter
        logic       tick_stb;   // one cycle per 1/16 bit tick
        logic [3:0] tick_idx;   // tick index within the bit
        logic       tx_active;  // transmitter shifting a frame
        logic       break_det;  // break detected by receiver
        logic       wait_mode;  // system in wait mode
    } sfc_line_s;

    typedef struct packed {
        logic       rx_input;    // selected receiver input
        logic       unit_enable; // serial unit running
        logic       nine_bit;
        logic       addr_wake;
        logic       idle_after_stop;
        logic       parity_en;
        logic       parity_odd;
    } sfc_cfg_s;
endpackage

// ==== src/sfc_sync.sv ====
`timescale 1ns/1ns
// three-stage synchroniser; a change counts once stages two and three agree
module sfc_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] stg;

    // stage one only feeds stage two, avoiding metastable fan-out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stg  <= 3'h7;
            dout <= 1'b1;
        end else begin
            stg <= {stg[1:0], din};
            if (stg[1] == stg[2]) begin
                dout <= stg[2];
            end
        end
    end
endmodule

// ==== src/sfc_top.sv ====
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
module sfc_top (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              rx_pin,
    input  wire sfc_pkg::sfc_line_s line,
    output sfc_pkg::sfc_cfg_s      cfg,
    output logic                   irq
);
    import sfc_pkg::*;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        have_aw;
        logic        have_w;
        logic [3:0]  awaddr;
        logic [7:0]  wbyte;
        logic        wlane;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  frame_ctl;
        logic [7:0]  alt_stat;
        logic [7:0]  alt_mask;
        logic [7:0]  alt_ctl2;
        logic [7:0]  second_stat;
        logic        rx_prev;
        sfc_cfg_s    cfg;
        logic        irq;
    } sfc_state_s;

    sfc_state_s st;
    sfc_state_s next_st;
    logic       rx_pin_sync;
    logic       tx_pin_sync;
    logic       rx_sel;
    logic       edge_evt;
    logic       berr_evt;
    logic       brk_evt;
    logic       bit_expect;
    logic       wr_fire;
    logic       alt_map;
    logic [1:0] bmode;
    logic [7:0] rd_byte;
    logic [7:0] w1c;

    // pin inputs from outside the clock domain are synchronised
    sfc_sync u_rx_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (rx_pin),
        .dout    (rx_pin_sync)
    );

    // single-wire mode reads the transmit pin, which the transmitter drives
    sfc_sync u_tx_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (line.rx_pin),
        .dout    (tx_pin_sync)
    );

    assign alt_map = st.second_stat[SS_ALT_MAP];
    assign bmode = st.alt_ctl2[AC2_BMODE_HI:AC2_BMODE_LO];

    // receiver source selection
    always_comb begin
        if (!st.frame_ctl[FC_LOOP]) begin
            rx_sel = rx_pin_sync;
        end else if (!st.frame_ctl[FC_SRC]) begin
            rx_sel = line.tx_bit;
        end else begin
            rx_sel = tx_pin_sync;
        end
    end

    // events: active edge, bit error at chosen tick, break
    always_comb begin
        bit_expect = line.tx_bit;
        edge_evt = st.second_stat[SS_RX_POL] ? (rx_sel && !st.rx_prev)
                                            : (!rx_sel && st.rx_prev);
        berr_evt = 1'b0;
        if (line.tx_active && line.tick_stb && rx_sel != bit_expect) begin
            case (bmode)
                BMODE_9:  berr_evt = (line.tick_idx == TICK_MODE1);
                BMODE_13: berr_evt = (line.tick_idx == TICK_MODE2);
                default:  berr_evt = 1'b0;  // off or reserved
            endcase
        end
        brk_evt = line.break_det && st.alt_ctl2[AC2_BRK_EN];
    end

    assign wr_fire = st.have_aw && st.have_w && !st.bvalid;

    // read mux follows the alternate map
    always_comb begin
        rd_byte = RESET_BYTE;
        case (s_axi_araddr)
            OFF_BAUD_OR_ALTSTAT:  rd_byte = alt_map ? (st.alt_stat & 8'h87) : RESET_BYTE;
            OFF_SPARE_OR_ALTCTL:  rd_byte = alt_map ? (st.alt_mask & 8'h83) : RESET_BYTE;
            OFF_FRAME_OR_ALTCTL2: rd_byte = alt_map ? st.alt_ctl2 : st.frame_ctl;
            OFF_SECOND_STATUS:    rd_byte = st.second_stat;
            default:              rd_byte = RESET_BYTE;
        endcase
    end

    // next state
    always_comb begin
        next_st = st;
        w1c = 8'h00;
        // write channel handshakes, either order
        next_st.awready = !st.have_aw && !st.awready;
        next_st.wready  = !st.have_w && !st.wready;
        if (st.awready && s_axi_awvalid) begin
            next_st.have_aw = 1'b1;
            next_st.awaddr  = s_axi_awaddr;
            next_st.awready = 1'b0;
        end
        if (st.wready && s_axi_wvalid) begin
            next_st.have_w = 1'b1;
            next_st.wbyte  = s_axi_wdata[7:0];
            next_st.wlane  = s_axi_wstrb[0];
            next_st.wready = 1'b0;
        end
        if (wr_fire) begin
            next_st.bvalid  = 1'b1;
            next_st.bresp   = (st.awaddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
            next_st.have_aw = 1'b0;
            next_st.have_w  = 1'b0;
            if (st.wlane && st.awaddr[1:0] == 2'h0) begin
                case (st.awaddr)
                    OFF_BAUD_OR_ALTSTAT: begin
                        if (alt_map) begin
                            w1c = st.wbyte & AS_W1C_MASK;
                        end
                    end
                    OFF_SPARE_OR_ALTCTL: begin
                        if (alt_map) begin
                            next_st.alt_mask = st.wbyte & 8'h83;
                        end
                    end
                    OFF_FRAME_OR_ALTCTL2: begin
                        if (alt_map) begin
                            next_st.alt_ctl2 = st.wbyte & 8'hE7;
                        end else begin
                            next_st.frame_ctl = st.wbyte;
                        end
                    end
                    OFF_SECOND_STATUS: next_st.second_stat = st.wbyte;
                    default: next_st.bresp = RESP_SLVERR;
                endcase
            end
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // read channel
        next_st.arready = !st.rvalid && !st.arready;
        if (st.arready && s_axi_arvalid) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rdata   = {24'h000000, rd_byte};
            next_st.rresp   = (s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        // sticky flags: the set wins over a same-cycle clear
        next_st.alt_stat = st.alt_stat & ~w1c;
        if (edge_evt) begin
            next_st.alt_stat[AS_EDGE] = 1'b1;
        end
        if (berr_evt) begin
            next_st.alt_stat[AS_BERR] = 1'b1;
            next_st.alt_stat[AS_BVAL] = rx_sel;
        end
        if (brk_evt) begin
            next_st.alt_stat[AS_BRK] = 1'b1;
        end
        next_st.alt_stat[6:3] = 4'h0;
        next_st.rx_prev = rx_sel;
        // configuration outputs
        next_st.cfg.rx_input        = rx_sel;
        next_st.cfg.unit_enable     = !(line.wait_mode && st.frame_ctl[FC_WAIT]);
        next_st.cfg.nine_bit        = st.frame_ctl[FC_LEN9];
        next_st.cfg.addr_wake       = st.frame_ctl[FC_WAKE];
        next_st.cfg.idle_after_stop = st.frame_ctl[FC_IDLE];
        next_st.cfg.parity_en       = st.frame_ctl[FC_PEN];
        next_st.cfg.parity_odd      = st.frame_ctl[FC_PTYPE];
        // level interrupt from unmasked sticky flags
        next_st.irq = |(next_st.alt_stat & st.alt_mask & AS_W1C_MASK);
    end

    // one register stage for all state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.rx_prev <= 1'b1;
            st.cfg.rx_input <= 1'b1;
            st.cfg.unit_enable <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign cfg           = st.cfg;
    assign irq           = st.irq;

    // checks: sticky flags; each is held until a write of one clears it,
    // and the set wins when an event meets its clear in the same cycle
    chk_edge_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        edge_evt |=> st.alt_stat[AS_EDGE]) else $error("edge flag not set");
    chk_edge_pol: assert property (@(posedge aclk) disable iff (!aresetn)
        edge_evt |-> (st.second_stat[SS_RX_POL] ? rx_sel : !rx_sel))
        else $error("edge of wrong polarity");
    chk_flags_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.alt_stat[AS_BRK] && !(wr_fire && alt_map && st.awaddr == OFF_BAUD_OR_ALTSTAT
         && st.wlane && st.wbyte[AS_BRK])) |=> st.alt_stat[AS_BRK])
        else $error("break flag lost");
    chk_edge_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.alt_stat[AS_EDGE] && !(wr_fire && alt_map && st.awaddr == OFF_BAUD_OR_ALTSTAT
         && st.wlane && st.wbyte[AS_EDGE])) |=> st.alt_stat[AS_EDGE])
        else $error("edge flag lost");
    chk_berr_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.alt_stat[AS_BERR] && !(wr_fire && alt_map && st.awaddr == OFF_BAUD_OR_ALTSTAT
         && st.wlane && st.wbyte[AS_BERR])) |=> st.alt_stat[AS_BERR])
        else $error("bit error flag lost");
    // a write of one clears the flag when no new event arrives with it
    chk_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && alt_map && st.awaddr == OFF_BAUD_OR_ALTSTAT && st.wlane
         && st.wbyte[AS_BRK] && !brk_evt) |=> !st.alt_stat[AS_BRK])
        else $error("break flag not cleared");
    // checks: bit error and break detection
    chk_berr_value: assert property (@(posedge aclk) disable iff (!aresetn)
        berr_evt |=> (st.alt_stat[AS_BERR] && st.alt_stat[AS_BVAL] == $past(rx_sel)))
        else $error("bit error value wrong");
    chk_berr_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        berr_evt |-> (line.tx_active && line.tick_stb && rx_sel != line.tx_bit))
        else $error("bit error without mismatch");
    chk_berr_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (bmode == BMODE_OFF || bmode == 2'h3) |-> !berr_evt)
        else $error("bit error in off mode");
    chk_berr_tick: assert property (@(posedge aclk) disable iff (!aresetn)
        (berr_evt && bmode == BMODE_9) |-> line.tick_idx == TICK_MODE1)
        else $error("bit error off the ninth tick");
    chk_berr_late: assert property (@(posedge aclk) disable iff (!aresetn)
        (berr_evt && bmode == BMODE_13) |-> line.tick_idx == TICK_MODE2)
        else $error("bit error off the thirteenth tick");
    chk_brk_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        brk_evt |-> st.alt_ctl2[AC2_BRK_EN]) else $error("break without enable");
    // the interrupt line is registered from the next flag values, so it changes
    // on the same edge as the flags; a change of mask takes effect one edge later
    chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> st.irq == |(st.alt_stat & $past(st.alt_mask) & AS_W1C_MASK))
        else $error("interrupt level wrong");
    // checks: receiver source; pin sources carry the synchroniser delay,
    // the internal loop path carries none
    chk_loop_source: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.frame_ctl[FC_LOOP] && !st.frame_ctl[FC_SRC]) |-> rx_sel == line.tx_bit)
        else $error("loop source wrong");
    chk_normal_source: assert property (@(posedge aclk) disable iff (!aresetn)
        !st.frame_ctl[FC_LOOP] |-> rx_sel == rx_pin_sync)
        else $error("normal source wrong");
    chk_wire_source: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.frame_ctl[FC_LOOP] && st.frame_ctl[FC_SRC]) |-> rx_sel == tx_pin_sync)
        else $error("single wire source wrong");
    // checks: register map and configuration outputs
    chk_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        st.alt_stat[6:3] == 4'h0) else $error("reserved bits set");
    chk_wait_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        (line.wait_mode && st.frame_ctl[FC_WAIT]) |=> !cfg.unit_enable)
        else $error("unit runs in wait");
    chk_wait_run: assert property (@(posedge aclk) disable iff (!aresetn)
        !(line.wait_mode && st.frame_ctl[FC_WAIT]) |=> cfg.unit_enable)
        else $error("unit stopped outside wait");
    chk_map_frame: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && alt_map) |=> $stable(st.frame_ctl))
        else $error("frame ctl written under alt map");
    chk_map_status: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && !alt_map) |-> w1c == 8'h00)
        else $error("status cleared under normal map");
    chk_map_alt: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && !alt_map) |=> ($stable(st.alt_mask) && $stable(st.alt_ctl2)))
        else $error("alt control written under normal map");
    chk_format_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> (cfg.nine_bit == $past(st.frame_ctl[FC_LEN9])
                  && cfg.addr_wake == $past(st.frame_ctl[FC_WAKE])
                  && cfg.idle_after_stop == $past(st.frame_ctl[FC_IDLE])))
        else $error("frame format output wrong");
    chk_parity_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> (cfg.parity_en == $past(st.frame_ctl[FC_PEN])
                  && cfg.parity_odd == $past(st.frame_ctl[FC_PTYPE])))
        else $error("parity output wrong");
endmodule

// ==== testbench/sfc_node.sv ====
`timescale 1ns/1ns
// remote serial node: our receive line and the shared single-wire line
module sfc_node (
    input  wire logic aclk,
    output logic      rx_pin,
    output logic      wire_pin
);
    // both lines idle high, as a terminated serial line does
    initial begin
        rx_pin = 1'b1;
        wire_pin = 1'b1;
    end
    // levels move just after an edge so the synchroniser sees clean steps
    task automatic put(input logic r, input logic w);
        @(posedge aclk);
        rx_pin <= r;
        wire_pin <= w;
    endtask
endmodule

// ==== testbench/sfc_top_bench.sv ====
`timescale 1ns/1ns
module sfc_top_bench;
    import sfc_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq, rxp, wpin;
    logic        txb, tstb, tact, brk, wmode;
    logic [3:0]  awaddr, araddr, wstrb, tidx;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    sfc_line_s   line;
    sfc_cfg_s    cfg;
    int          miscompares, cmp_count;

    // line bundle is built from the node and the bench's transmitter stand-in
    assign line = {wpin, txb, tstb, tidx, tact, brk, wmode};

    sfc_node node (.aclk(aclk), .rx_pin(rxp), .wire_pin(wpin));

    sfc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_pin(rxp), .line(line), .cfg(cfg), .irq(irq));

    // 10 MHz bus clock
    always #50 aclk = ~aclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // write one byte; address and data are released each when taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) begin
            miscompares++;
            test_done;
        end
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        // an idle edge keeps two drives of one strobe out of one time step
        @(posedge aclk);
    endtask

    // read one word and compare it whole: upper bits must read zero
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) begin
            miscompares++;
            test_done;
        end
        rready <= 1'b0;
        chk(rdata, {24'h0, exp});
        // a misaligned read is refused with a slave error
        chk({30'h0, rresp}, {30'h0, (a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR});
        @(posedge aclk);
    endtask

    // one bit-error sample point offered by the transmitter stand-in
    task automatic tick(input logic [3:0] idx, input logic tb);
        tact <= 1'b1;
        txb <= tb;
        tidx <= idx;
        tstb <= 1'b1;
        @(posedge aclk);
        tstb <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask

    task automatic t_frame;
        logic [7:0] v [3] = '{8'h1F, 8'h0A, 8'h15};
        foreach (v[i]) begin
            wr(OFF_FRAME_OR_ALTCTL2, v[i], RESP_OKAY);
            rdc(OFF_FRAME_OR_ALTCTL2, v[i]);
            chk(cfg[4:0], v[i][4:0]);
        end
        // misaligned access is refused and changes nothing
        wr(4'h9, 8'hFF, RESP_SLVERR);
        rdc(OFF_FRAME_OR_ALTCTL2, 8'h15);
        rdc(4'h9, 8'h00);
    endtask

    task automatic t_loop;
        node.put(1'b1, 1'b0);
        tact <= 1'b1; // transmitter stand-in kept running while loop is used
        wr(OFF_FRAME_OR_ALTCTL2, 8'h80, RESP_OKAY);
        txb <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(cfg.rx_input, 1'b0);
        txb <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(cfg.rx_input, 1'b1);
        wr(OFF_FRAME_OR_ALTCTL2, 8'hA0, RESP_OKAY);
        repeat (6) @(posedge aclk);
        chk(cfg.rx_input, 1'b0);
        wr(OFF_FRAME_OR_ALTCTL2, 8'h20, RESP_OKAY);
        repeat (6) @(posedge aclk);
        chk(cfg.rx_input, 1'b1);
    endtask

    task automatic t_wait;
        wr(OFF_FRAME_OR_ALTCTL2, 8'h40, RESP_OKAY);
        wmode <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(cfg.unit_enable, 1'b0);
        wr(OFF_FRAME_OR_ALTCTL2, 8'h15, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(cfg.unit_enable, 1'b1);
        wmode <= 1'b0;
    endtask

    task automatic t_map;
        wr(OFF_SECOND_STATUS, 8'h80, RESP_OKAY);
        rdc(OFF_FRAME_OR_ALTCTL2, 8'h00);
        wr(OFF_FRAME_OR_ALTCTL2, 8'hFF, RESP_OKAY);
        rdc(OFF_FRAME_OR_ALTCTL2, 8'hE7);
        chk(cfg[4:0], 5'h15);
        wr(OFF_FRAME_OR_ALTCTL2, 8'h00, RESP_OKAY);
        wr(OFF_BAUD_OR_ALTSTAT, 8'hFF, RESP_OKAY);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h00);
    endtask

    task automatic t_edge;
        wr(OFF_SPARE_OR_ALTCTL, 8'h80, RESP_OKAY);
        node.put(1'b0, 1'b1);
        repeat (8) @(posedge aclk);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h80);
        chk(irq, 1'b1);
        wr(OFF_BAUD_OR_ALTSTAT, 8'h7C, RESP_OKAY);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h80);
        wr(OFF_BAUD_OR_ALTSTAT, 8'h80, RESP_OKAY);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h00);
        chk(irq, 1'b0);
        // rising polarity: only the rising step counts
        wr(OFF_SECOND_STATUS, 8'h88, RESP_OKAY);
        node.put(1'b1, 1'b1);
        repeat (8) @(posedge aclk);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h80);
        wr(OFF_BAUD_OR_ALTSTAT, 8'h80, RESP_OKAY);
        node.put(1'b0, 1'b1);
        repeat (8) @(posedge aclk);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h00);
        wr(OFF_SECOND_STATUS, 8'h80, RESP_OKAY);
    endtask

    task automatic t_err;
        wr(OFF_SPARE_OR_ALTCTL, 8'h02, RESP_OKAY);
        tick(4'h8, 1'b1);
        tick(4'hC, 1'b1);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h00);
        wr(OFF_FRAME_OR_ALTCTL2, 8'h04, RESP_OKAY);
        tick(4'h8, 1'b1);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h00);
        tick(4'hC, 1'b1);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h02);
        chk(irq, 1'b1);
        wr(OFF_SPARE_OR_ALTCTL, 8'h00, RESP_OKAY);
        chk(irq, 1'b0);
        wr(OFF_BAUD_OR_ALTSTAT, 8'h02, RESP_OKAY);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h00);
        // break: disabled detector ignores the pulse
        brk <= 1'b1;
        @(posedge aclk);
        brk <= 1'b0;
        repeat (3) @(posedge aclk);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h00);
        wr(OFF_FRAME_OR_ALTCTL2, 8'h01, RESP_OKAY);
        wr(OFF_SPARE_OR_ALTCTL, 8'h01, RESP_OKAY);
        brk <= 1'b1;
        @(posedge aclk);
        brk <= 1'b0;
        repeat (3) @(posedge aclk);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h01);
        chk(irq, 1'b1);
        wr(OFF_BAUD_OR_ALTSTAT, 8'h01, RESP_OKAY);
        // high sampled where low was sent, at the ninth tick
        node.put(1'b1, 1'b1);
        wr(OFF_FRAME_OR_ALTCTL2, 8'h02, RESP_OKAY);
        tick(4'hC, 1'b0);
        tick(4'h8, 1'b0);
        rdc(OFF_BAUD_OR_ALTSTAT, 8'h06);
    endtask

    // reset, then scenarios in turn
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {txb, tstb, tact, brk, wmode, awaddr, araddr, wstrb, tidx, wdata} = '0;
        miscompares = 0;
        cmp_count = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({25'h0, cfg}, 32'h60);
        chk(irq, 1'b0);
        rdc(OFF_SECOND_STATUS, 8'h00);
        rdc(OFF_FRAME_OR_ALTCTL2, 8'h00);
        t_frame;
        t_loop;
        t_wait;
        t_map;
        t_edge;
        t_err;
        test_done;
    end
endmodule
